// ### verilog/asc_defs.vh
// Purpose: constants for the converter control register block
// Assumes: 32-bit APB data, word-aligned registers
// Notes:   offsets are byte addresses
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define ASC_OFS_CTRL1     8'h00
`define ASC_OFS_CTRL1_CLR 8'h04
`define ASC_OFS_CTRL1_SET 8'h08
`define ASC_OFS_CTRL1_INV 8'h0c
`define ASC_OFS_SEQ       8'h10
`define ASC_OFS_SEQ_CLR   8'h14
`define ASC_OFS_SEQ_SET   8'h18
`define ASC_OFS_SEQ_INV   8'h1c
`define ASC_OFS_TIM       8'h20
`define ASC_OFS_TIM_CLR   8'h24
`define ASC_OFS_TIM_SET   8'h28
`define ASC_OFS_TIM_INV   8'h2c

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define ASC_MASK_CTRL1 32'h0000_a7f4
`define ASC_MASK_SEQ   32'h0000_f43f
`define ASC_MASK_TIM   32'h0000_9fff
`define ASC_RST_CTRL1  32'h0000_0000
`define ASC_RST_SEQ    32'h0000_0000
`define ASC_RST_TIM    32'h0000_0000

// ****************************************************************
// field positions
// ****************************************************************
`define ASC_C1_ON      15
`define ASC_C1_TRIGGER_SOURCE    7:5
`define ASC_C1_STOP_ON_INTERRUPT 4
`define ASC_C1_AUTO_START    2
`define ASC_C1_SAMPLING_BIT    1
`define ASC_C1_DONE    0
`define ASC_SQ_REFERENCE_SELECT    15:13
`define ASC_SQ_OFFSET_CAL_ENABLE  12
`define ASC_SQ_SCAN_ENABLE   10
`define ASC_SQ_BUFFER_FILL_STATUS    7
`define ASC_SQ_INTERRUPT_INTERVAL    5:2
`define ASC_SQ_BUFFER_SPLIT_MODE    1
`define ASC_SQ_ALTERNATE_MUX_SAMPLING    0
`define ASC_TM_CONV_CLOCK_SOURCE    15
`define ASC_TM_AUTO_SAMPLE_TIME    12:8
`define ASC_TM_CONV_CLOCK_DIVIDER    7:0

// ****************************************************************
// trigger codes and timing
// ****************************************************************
`define ASC_TRIG_SW    3'h0
`define ASC_TRIG_PIN   3'h1
`define ASC_TRIG_TMR   3'h2
`define ASC_TRIG_AUTO  3'h7
`define ASC_CONV_TAD   4'hc

`endif

// ### verilog/asc_tad_gen.v
// Purpose: conversion clock period tick generator from the bus clock
// Assumes: one tick per 2*(divider+1) bus clock periods
// Notes:   divider is reloaded at a period boundary and while run is low
`timescale 1ns/100ps
module asc_tad_gen (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // control
  input  wire       run,
  input  wire [7:0] divider,
  // tick out
  output reg        tick
);

  reg [8:0] count;
  reg [8:0] period_end;

  // ****************************************************************
  // divider
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count      <= 9'h000;
      period_end <= 9'h001;
      tick       <= 1'b0;
    end else if (!run) begin
      count      <= 9'h000;
      period_end <= {divider, 1'b1};
      tick       <= 1'b0;
    end else if (count == period_end) begin
      count      <= 9'h000;
      period_end <= {divider, 1'b1};
      tick       <= 1'b1;
    end else begin
      count <= count + 9'h001;
      tick  <= 1'b0;
    end
  end

endmodule // asc_tad_gen

// ### verilog/asc_top.v
// Purpose: converter control registers and sample/convert sequencer
// Assumes: APB slave, clock 25 MHz, asynchronous active-high reset
// Notes:   pin inputs pass three flip-flops before use
//
// Behaviour
// - clear alias of first control register clears bits written one.
// - set alias of first control register sets bits written one.
// - invert alias of first control register toggles bits written one.
// - second control register has clear, set and invert aliases.
// - reference field selects supply rails or external pins; 1xx as 000.
// - offset calibration ties both hold inputs to negative reference.
// - scan enable takes mux A positive input from scan sequence, unless offset calibration is on.
// - fill status reads one while filling upper half, else zero.
// - interrupt after every (interval plus one) sequences.
// - buffer mode selects two 8-word halves or one 16-word buffer.
// - alternate sampling uses A first, then B, A, B.
// - clock source bit picks RC oscillator or bus-derived clock.
// - auto-sample time is 1 to 31 conversion clocks; zero forbidden.
// - bus-derived conversion clock period is 2*(divider+1) bus clocks.
// - control fields reset to zero.
// - software trigger: clearing sampling bit starts conversion.
// - auto trigger: sample counter ends sampling after auto-sample time.
// - auto-start restarts sampling after each conversion, sets sampling.
// - stop-on-interrupt clears auto-start at the first interrupt.
`timescale 1ns/100ps
`include "asc_defs.vh"
module asc_top (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // triggers and rc oscillator
  input  wire        trig_pin,
  input  wire        timer_match,
  input  wire        rc_clock_in,
  // analog front end control
  output reg         sha_sampling,
  output reg         mux_b_select,
  output reg         scan_mux_a,
  output reg         sha_to_neg_ref,
  output reg         ref_pos_ext,
  output reg         ref_neg_ext,
  output reg         rc_osc_enable,
  // result store and events
  output reg         conv_start,
  output reg         result_write,
  output reg  [3:0]  result_addr,
  output reg         seq_event
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [31:0] alias_op;
    input [31:0] old;
    input [31:0] wd;
    input [1:0]  kind;
    begin
      case (kind)
        2'h0:    alias_op = wd;
        2'h1:    alias_op = old & ~wd;
        2'h2:    alias_op = old | wd;
        2'h3:    alias_op = old ^ wd;
        default: alias_op = old;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nv;
    input [31:0] mask;
    begin
      merge = (old & ~mask) | (nv & mask);
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [31:0] ctrl1;
  reg  [31:0] seq_ctrl;
  reg  [31:0] tim_ctrl;
  reg         done;
  reg         buffer_fill_status;
  reg  [1:0]  state;
  reg  [4:0]  auto_sample_time_count;
  reg  [3:0]  conv_count;
  reg  [3:0]  seq_count;
  reg  [3:0]  fill_index;
  reg  [2:0]  pin_sync;
  reg         pin_level;
  reg  [2:0]  rc_sync;
  reg         rc_level;
  reg         pin_edge;
  reg         rc_tick;
  wire        bus_tick;
  reg  [31:0] next_ctrl1;
  reg  [31:0] rd_word;
  reg         rd_hit;

  wire access    = psel & penable & pready;
  wire wr        = access & pwrite & rd_hit;
  wire [1:0] wk  = paddr[3:2];
  wire wr_c1     = wr & (paddr[7:4] == 4'h0);
  wire wr_sq     = wr & (paddr[7:4] == 4'h1);
  wire wr_tm     = wr & (paddr[7:4] == 4'h2);
  wire mod_on    = ctrl1[`ASC_C1_ON];
  wire [2:0] trigger_source = ctrl1[`ASC_C1_TRIGGER_SOURCE];
  wire auto_start      = ctrl1[`ASC_C1_AUTO_START];
  wire tad       = tim_ctrl[`ASC_TM_CONV_CLOCK_SOURCE] ? rc_tick : bus_tick;
  wire sw_sampling_bit_1 = wr_c1 & next_ctrl1[`ASC_C1_SAMPLING_BIT];
  wire sw_sampling_bit_0 = wr_c1 & ~next_ctrl1[`ASC_C1_SAMPLING_BIT];
  wire conv_end  = (state == ST_CONV) & tad &
                   (conv_count == `ASC_CONV_TAD - 4'h1);
  wire seq_last  = seq_count == seq_ctrl[`ASC_SQ_INTERRUPT_INTERVAL];
  wire irq_now   = conv_end & seq_last;

  // ****************************************************************
  // conversion clock
  // ****************************************************************
  asc_tad_gen u_tad (
    .clock   (clock),
    .rst     (rst),
    .run     (mod_on & ~tim_ctrl[`ASC_TM_CONV_CLOCK_SOURCE]),
    .divider (tim_ctrl[`ASC_TM_CONV_CLOCK_DIVIDER]),
    .tick    (bus_tick)
  );

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
      rc_sync   <= 3'h0;
      rc_level  <= 1'b0;
      pin_edge  <= 1'b0;
      rc_tick   <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], trig_pin};
      rc_sync  <= {rc_sync[1:0], rc_clock_in};
      pin_edge <= 1'b0;
      rc_tick  <= 1'b0;
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
        pin_edge  <= pin_sync[2] & ~pin_level;
      end
      if (rc_sync[1] == rc_sync[2]) begin
        rc_level <= rc_sync[2];
        rc_tick  <= rc_sync[2] & ~rc_level;
      end
    end
  end

  // ****************************************************************
  // first control register write value
  // ****************************************************************
  always @* begin
    next_ctrl1 = alias_op(ctrl1, pwdata, wk);
    next_ctrl1[`ASC_C1_SAMPLING_BIT] = pwdata[`ASC_C1_SAMPLING_BIT];
    if (wk == 2'h1)
      next_ctrl1[`ASC_C1_SAMPLING_BIT] = ~pwdata[`ASC_C1_SAMPLING_BIT] & sha_sampling;
    if (wk == 2'h2)
      next_ctrl1[`ASC_C1_SAMPLING_BIT] = pwdata[`ASC_C1_SAMPLING_BIT] | sha_sampling;
    if (wk == 2'h3)
      next_ctrl1[`ASC_C1_SAMPLING_BIT] = pwdata[`ASC_C1_SAMPLING_BIT] ^ sha_sampling;
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl1    <= `ASC_RST_CTRL1;
      seq_ctrl <= `ASC_RST_SEQ;
      tim_ctrl <= `ASC_RST_TIM;
    end else begin
      if (wr_c1)
        ctrl1 <= merge(ctrl1, next_ctrl1, `ASC_MASK_CTRL1);
      if (irq_now & ctrl1[`ASC_C1_STOP_ON_INTERRUPT])
        ctrl1[`ASC_C1_AUTO_START] <= 1'b0;
      if (wr_sq)
        seq_ctrl <= merge(seq_ctrl, alias_op(seq_ctrl, pwdata, wk),
                          `ASC_MASK_SEQ);
      if (wr_tm)
        tim_ctrl <= merge(tim_ctrl, alias_op(tim_ctrl, pwdata, wk),
                          `ASC_MASK_TIM);
    end
  end

  // ****************************************************************
  // sample and convert sequencer
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state        <= ST_IDLE;
      auto_sample_time_count   <= 5'h00;
      conv_count   <= 4'h0;
      seq_count    <= 4'h0;
      fill_index   <= 4'h0;
      buffer_fill_status         <= 1'b0;
      done         <= 1'b0;
      mux_b_select <= 1'b0;
      conv_start   <= 1'b0;
      result_write <= 1'b0;
      result_addr  <= 4'h0;
      seq_event    <= 1'b0;
    end else begin
      conv_start   <= 1'b0;
      result_write <= 1'b0;
      seq_event    <= 1'b0;
      // software clears done; a completion in the same cycle wins
      if (wr_c1 & ~next_ctrl1[`ASC_C1_DONE])
        done <= 1'b0;
      if (!mod_on) begin
        state        <= ST_IDLE;
        seq_count    <= 4'h0;
        fill_index   <= 4'h0;
        buffer_fill_status         <= 1'b0;
        mux_b_select <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            auto_sample_time_count <= 5'h00;
            if (auto_start | (sw_sampling_bit_1 & ~auto_start)) begin
              state <= ST_SAMPLE;
              done  <= 1'b0;
            end
          end
          ST_SAMPLE: begin
            if (tad & (auto_sample_time_count != 5'h1f))
              auto_sample_time_count <= auto_sample_time_count + 5'h01;
            if ((trigger_source == `ASC_TRIG_SW & sw_sampling_bit_0) |
                (trigger_source == `ASC_TRIG_PIN & pin_edge) |
                (trigger_source == `ASC_TRIG_TMR & timer_match) |
                (trigger_source == `ASC_TRIG_AUTO & tad &
                 auto_sample_time_count + 5'h01 >= tim_ctrl[`ASC_TM_AUTO_SAMPLE_TIME])) begin
              state      <= ST_CONV;
              conv_count <= 4'h0;
              conv_start <= 1'b1;
            end
          end
          ST_CONV: begin
            if (tad)
              conv_count <= conv_count + 4'h1;
            if (conv_end) begin
              done         <= 1'b1;
              result_write <= 1'b1;
              if (seq_ctrl[`ASC_SQ_BUFFER_SPLIT_MODE])
                result_addr <= {buffer_fill_status, fill_index[2:0]};
              else
                result_addr <= fill_index;
              fill_index   <= fill_index + 4'h1;
              mux_b_select <= seq_ctrl[`ASC_SQ_ALTERNATE_MUX_SAMPLING] &
                              ~mux_b_select;
              auto_sample_time_count   <= 5'h00;
              if (seq_last) begin
                seq_count  <= 4'h0;
                seq_event  <= 1'b1;
                fill_index <= 4'h0;
                if (seq_ctrl[`ASC_SQ_BUFFER_SPLIT_MODE])
                  buffer_fill_status <= ~buffer_fill_status;
              end else begin
                seq_count <= seq_count + 4'h1;
              end
              if (auto_start & ~(seq_last & ctrl1[`ASC_C1_STOP_ON_INTERRUPT]))
                state <= ST_SAMPLE;
              else
                state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // front end control outputs
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sha_sampling   <= 1'b0;
      scan_mux_a     <= 1'b0;
      sha_to_neg_ref <= 1'b0;
      ref_pos_ext    <= 1'b0;
      ref_neg_ext    <= 1'b0;
      rc_osc_enable  <= 1'b0;
    end else begin
      sha_sampling   <= (state == ST_SAMPLE) & ~(conv_start);
      sha_to_neg_ref <= seq_ctrl[`ASC_SQ_OFFSET_CAL_ENABLE];
      scan_mux_a     <= seq_ctrl[`ASC_SQ_SCAN_ENABLE] &
                        ~seq_ctrl[`ASC_SQ_OFFSET_CAL_ENABLE];
      ref_pos_ext    <= ~seq_ctrl[15] & seq_ctrl[13];
      ref_neg_ext    <= ~seq_ctrl[15] & seq_ctrl[14];
      rc_osc_enable  <= mod_on & tim_ctrl[`ASC_TM_CONV_CLOCK_SOURCE];
    end
  end

  // ****************************************************************
  // apb read decode
  // ****************************************************************
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      `ASC_OFS_CTRL1: begin
        rd_word = ctrl1 & `ASC_MASK_CTRL1;
        rd_word[`ASC_C1_SAMPLING_BIT] = sha_sampling;
        rd_word[`ASC_C1_DONE] = done;
      end
      `ASC_OFS_SEQ: begin
        rd_word = seq_ctrl & `ASC_MASK_SEQ;
        rd_word[`ASC_SQ_BUFFER_FILL_STATUS] = buffer_fill_status;
      end
      `ASC_OFS_TIM:      rd_word = tim_ctrl & `ASC_MASK_TIM;
      `ASC_OFS_CTRL1_CLR,
      `ASC_OFS_CTRL1_SET,
      `ASC_OFS_CTRL1_INV,
      `ASC_OFS_SEQ_CLR,
      `ASC_OFS_SEQ_SET,
      `ASC_OFS_SEQ_INV,
      `ASC_OFS_TIM_CLR,
      `ASC_OFS_TIM_SET,
      `ASC_OFS_TIM_INV:  rd_word = 32'h0000_0000;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // ****************************************************************
  // apb handshake: one wait state, answer registered
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_word;
    end
  end

endmodule // asc_top

// ### tb/asc_top_props.sv
// Purpose: bus and sequencer checks for asc_top
// Assumes: one clock, rst asynchronous active high
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module asc_top_props (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // sequencer
  input wire        sha_sampling,
  input wire        scan_mux_a,
  input wire        sha_to_neg_ref,
  input wire        conv_start,
  input wire        result_write,
  input wire        seq_event
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence one_wait_s;
    !pready ##1 pready;
  endsequence
  a_one_wait: assert property (setup_s |-> one_wait_s)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_read_zero: assert property (
    pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error answer malformed");
  a_offset_cal_enable_scan: assert property (
    sha_to_neg_ref |-> !scan_mux_a)
    else $error("scan active during calibration");
  a_conv_on_end: assert property (
    $rose(conv_start) |=> $fell(sha_sampling))
    else $error("sampling not ended by conversion");
  a_conv_holds: assert property (
    conv_start |=> (!sha_sampling && !result_write) [*8])
    else $error("conversion cut short");
  a_write_pulse: assert property (result_write |=> !result_write)
    else $error("result write too long");
  a_event_at_end: assert property (seq_event |-> result_write)
    else $error("event without result");
endmodule // asc_top_props

// ### tb/asc_top_bench.sv
// Purpose: self-checking bench for asc_top
// Assumes: 25 MHz clock, reset held 12 cycles
// Notes:   random register traffic plus sequencer corners
`timescale 1ns/100ps
module asc_top_bench;
  reg          clock, rst, psel, penable, pwrite;
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata;
  reg          trig_pin, timer_match, rc_clock_in;
  reg  [1:0]   rcd;
  wire         pready, pslverr, sha_sampling, mux_b_select, scan_mux_a;
  wire         sha_to_neg_ref, ref_pos_ext, ref_neg_ext, rc_osc_enable;
  wire         conv_start, result_write, seq_event;
  wire [31:0]  prdata;
  wire [3:0]   result_addr;
  wire [3:0]   dec_seen = {ref_pos_ext, ref_neg_ext,
                           sha_to_neg_ref, scan_mux_a};
  int          num_errors, n_tests, n_wr, n_ev, n_cs, i, k, c, r;
  logic [4:0]  addrs[$];
  logic [31:0] rd, d, md[3], mk[3];
  logic        er;

  asc_top asc_top_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trig_pin(trig_pin), .timer_match(timer_match),
    .rc_clock_in(rc_clock_in), .sha_sampling(sha_sampling),
    .mux_b_select(mux_b_select), .scan_mux_a(scan_mux_a),
    .sha_to_neg_ref(sha_to_neg_ref), .ref_pos_ext(ref_pos_ext),
    .ref_neg_ext(ref_neg_ext), .rc_osc_enable(rc_osc_enable),
    .conv_start(conv_start), .result_write(result_write),
    .result_addr(result_addr), .seq_event(seq_event));

  always #20 clock = ~clock;

  // rc clock of four bus clocks and event monitor
  always @(posedge clock) begin
    rcd <= rcd + 2'h1;
    rc_clock_in <= rcd[1];
    if (result_write === 1'b1) begin
      n_wr++;
      addrs.push_back({mux_b_select, result_addr});
    end
    if (seq_event === 1'b1) n_ev++;
    if (conv_start === 1'b1) n_cs++;
  end

  // ****
  // tasks and functions
  // ****
  function logic [31:0] apply_op(input logic [31:0] o, w, input int t,
                                 input logic [31:0] m);
    case (t)
      0: apply_op = w & m;
      1: apply_op = o & ~(w & m);
      2: apply_op = o | (w & m);
      default: apply_op = o ^ (w & m);
    endcase
  endfunction

  function logic [31:0] exp_dec(input logic [31:0] s);
    exp_dec = {s[15:13] == 3'h1 || s[15:13] == 3'h3,
               s[15:13] == 3'h2 || s[15:13] == 3'h3, s[12], s[10] & !s[12]};
  endfunction

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task wait_for(input int tgt);
    int t;
    t = 0;
    while (n_wr < tgt && t < 3000) begin
      @(posedge clock);
      t++;
    end
    if (n_wr < tgt) begin
      num_errors++;
      conclude();
    end
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    clock = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; trig_pin = 0; timer_match = 0; rc_clock_in = 0;
    rcd = 2'h0; num_errors = 0; n_tests = 0; n_wr = 0; n_ev = 0; n_cs = 0;
    mk[0] = 32'h0000_27f4; mk[1] = 32'h0000_f43f; mk[2] = 32'h0000_9fff;
    c = $urandom(32'h498e979d);
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 3; i++) begin
      md[i] = 32'h0;
      xfer(0, i * 16, 32'h0);
      check("reset value", rd, 32'h0);
    end
    for (i = 0; i < 8; i++) begin
      md[1] = {16'h0, i[2:0], i[0], 1'b0, i[1], 10'h0};
      xfer(1, 8'h10, md[1]);
      xfer(0, 8'h10, 32'h0);
      check("decode", dec_seen, exp_dec(md[1]));
    end
    for (i = 0; i < 60; i++) begin
      r = $urandom % 3;
      k = $urandom % 4;
      d = $urandom & mk[r];
      xfer(1, r * 16 + k * 4, d);
      md[r] = apply_op(md[r], d, k, mk[r]);
      xfer(0, r * 16, 32'h0);
      check("register", rd, md[r]);
      check("decode", dec_seen, exp_dec(md[1]));
    end
    xfer(1, 8'h30, 32'hffff_ffff);
    check("unmapped write", er, 1);
    xfer(0, 8'h30, 32'h0);
    check("unmapped read", rd, 32'h0);
    for (i = 0; i < 3; i++) xfer(1, i * 16, 32'h0);
    // software, pin and timer endings of sampling
    xfer(1, 8'h20, 32'h0000_0100);
    for (i = 0; i < 3; i++) begin
      c = n_wr;
      xfer(1, 8'h00, 32'h8000 | (i << 5));
      xfer(1, 8'h08, 32'h2);
      repeat (2) @(posedge clock);
      check("sampling", sha_sampling, 1);
      if (i == 0) xfer(1, 8'h04, 32'h2);
      else if (i == 1) begin
        trig_pin <= 1'b1;
        repeat (6) @(posedge clock);
        trig_pin <= 1'b0;
      end else begin
        timer_match <= 1'b1;
        @(posedge clock);
        timer_match <= 1'b0;
      end
      wait_for(c + 1);
      check("starts", n_cs, n_wr);
      xfer(1, 8'h00, 32'h0);
    end
    // auto conversion, split halves, interrupt every second sequence
    xfer(1, 8'h10, 32'h7);
    addrs = {};
    c = n_wr;
    k = n_ev;
    xfer(1, 8'h00, 32'h80e4);
    wait_for(c + 2);
    xfer(0, 8'h10, 32'h0);
    check("fill status", rd[7], 1);
    wait_for(c + 4);
    xfer(1, 8'h04, 32'h4);
    repeat (200) @(posedge clock);
    // mux bit is the setting for the sample after each result
    for (i = 0; i < 4; i++) begin
      d = {~i[0], i[1], 2'b0, i[0]};
      check("addr", addrs[i], d);
    end
    check("events", n_ev - k, (n_wr - c) / 2);
    xfer(0, 8'h10, 32'h0);
    check("fill status", rd[7], (n_ev - k) % 2);
    // stop on first interrupt, single buffer, rc source
    xfer(1, 8'h00, 32'h0);
    xfer(1, 8'h10, 32'h0);
    xfer(1, 8'h20, 32'h0000_8200);
    addrs = {};
    c = n_wr;
    xfer(1, 8'h00, 32'h80f4);
    wait_for(c + 1);
    check("rc enable", rc_osc_enable, 1);
    repeat (300) @(posedge clock);
    xfer(0, 8'h00, 32'h0);
    check("auto start", rd[2], 0);
    check("count", n_wr, c + 1);
    check("addr0", addrs[0], 32'h0);
    xfer(1, 8'h00, 32'h0);
    @(posedge clock);
    check("rc enable", rc_osc_enable, 0);
    conclude();
  end
endmodule // asc_top_bench

bind asc_top asc_top_props asc_top_props_inst (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .sha_sampling(sha_sampling), .scan_mux_a(scan_mux_a),
  .sha_to_neg_ref(sha_to_neg_ref), .conv_start(conv_start),
  .result_write(result_write), .seq_event(seq_event));
